/* core/rca_consts.svh */
// register offsets, field positions, reset values and timing figures of the calibration/alarm block
// Contract
// - signed correction byte times four gives the pulses applied each minute.
// - a negative correction removes pulses from the timekeeping counter.
// - adjustment happens at the fifteen-second boundaries of the seconds count.
// - bit 15 arms the alarm; hardware clears it at the final alarm.
// - mask field 13:10 selects which time digits must match to fire.
// - repeat count zero and endless bit clear gives exactly one alarm.
// - repeat count FFh gives up to 255 repetitions.
// - the repeat count decrements by one after each alarm.
// - at count zero one final alarm fires, then the arm bit clears.
// - with endless bit 14 set the count wraps from zero to FFh.
// - every alarm event raises an interrupt request.
// - an alarm pulse output toggles on each alarm, half the alarm rate.
`ifndef RCA_CONSTS_SVH
`define RCA_CONSTS_SVH

// apb byte offsets
`define RCA_OFS_CAL       8'h00
`define RCA_OFS_ALCFG     8'h04
`define RCA_OFS_ALTIME    8'h08
`define RCA_OFS_ALDATE    8'h0c
`define RCA_OFS_STATUS    8'h10

// alarm config fields
`define RCA_ARM_BIT       15
`define RCA_ENDLESS_BIT   14
`define RCA_MASK_HI       13
`define RCA_MASK_LO       10
`define RCA_RPT_HI        7
`define RCA_RPT_LO        0
`define RCA_RPT_WRAP      8'hff

// status fields
`define RCA_ST_EVENT      0
`define RCA_ST_PULSE      1
`define RCA_ST_CALBUSY    2

// reset values
`define RCA_CAL_RST       8'h00
`define RCA_ALCFG_RST     16'h0000

// bcd second values at which the adjustment runs
`define RCA_SEC_00        7'h00
`define RCA_SEC_15        7'h15
`define RCA_SEC_30        7'h30
`define RCA_SEC_45        7'h45

// adjustment slices per minute; correction is multiplied by this
`define RCA_SLICES        4

`endif

/* core/rca_pkg.sv */
// types shared by the calibration/alarm block
package rca_pkg;

  // current time from the timekeeping counters, bcd digits
  typedef struct packed {
    logic [7:0] year;
    logic [4:0] month;
    logic [5:0] day;
    logic [2:0] wday;
    logic [5:0] hour;
    logic [6:0] min;
    logic [6:0] sec;
    logic       half;
  } rca_time_t;

  // alarm configuration and repeat register
  typedef struct packed {
    logic       arm;
    logic       endless;
    logic [3:0] mask;
    logic [1:0] unused;
    logic [7:0] rpt;
  } rca_alcfg_t;

  // alarm compare value (no year digits)
  typedef struct packed {
    logic [4:0] month;
    logic [5:0] day;
    logic [2:0] wday;
    logic [5:0] hour;
    logic [6:0] min;
    logic [6:0] sec;
  } rca_alval_t;

  // calibration pulse requests towards the timekeeping counter
  typedef struct packed {
    logic add;
    logic drop;
  } rca_adj_t;

endpackage

/* core/rca_cal.sv */
// calibration engine: spreads the signed correction over four slices a minute
`timescale 1ns/1ps
`default_nettype none
`include "rca_consts.svh"

module rca_cal (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // control
  input  wire logic signed [7:0] corr,
  input  wire logic              boundary,
  // adjustment pulses
  output rca_pkg::rca_adj_t      adj,
  output logic                   busy
);
  import rca_pkg::*;

  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic       neg_reg;
  logic [7:0] mag;
  rca_adj_t   adj_next;

  // magnitude of the signed byte; -128 gives 128 which still fits
  assign mag      = corr[7] ? 8'(-corr) : 8'(corr);
  assign cnt_next = boundary ? mag : ((cnt_reg != 8'h00) ? cnt_reg - 8'h01 : 8'h00);
  // one pulse a cycle, |corr| per slice, four slices give 4*|corr| a minute
  assign adj_next.add  = (cnt_reg != 8'h00) && !boundary && !neg_reg;
  assign adj_next.drop = (cnt_reg != 8'h00) && !boundary && neg_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg <= 8'h00;
      neg_reg <= 1'b0;
      adj     <= '0;
    end else begin
      cnt_reg <= cnt_next;
      adj     <= adj_next;
      if (boundary) begin
        neg_reg <= corr[7];
      end
    end
  end

  assign busy = (cnt_reg != 8'h00);

  ////////////////////////////////////////////////////////////////////////////
  // checks

  // pulse direction follows the sign latched at the boundary
  drop_sign_a: assert property (@(posedge clk) disable iff (rst) adj.drop |-> $past(neg_reg))
    else $error("drop pulse with positive correction");

  add_sign_a: assert property (@(posedge clk) disable iff (rst) adj.add |-> !$past(neg_reg))
    else $error("add pulse with negative correction");

  // a nonzero correction at a boundary starts a pulse burst two cycles later
  burst_start_a: assert property (@(posedge clk) disable iff (rst)
      (boundary && corr != 8'sh00) ##1 !boundary |=> (adj.add || adj.drop))
    else $error("correction burst did not start");

  // a correction of one yields exactly one pulse per slice
  single_pulse_a: assert property (@(posedge clk) disable iff (rst)
      (boundary && corr == 8'sh01) ##1 !boundary[*2] |-> adj.add ##1 !adj.add)
    else $error("unit correction gave wrong pulse count");

endmodule
`default_nettype wire

/* core/rca_top.sv */
// calibration and alarm logic of the clock/calendar unit with its apb register file
//
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "rca_consts.svh"

module rca_top (
  // clock and reset
  input  wire logic              CLK,
  input  wire logic              RST,
  // apb slave
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [7:0]        PADDR,
  input  wire logic [31:0]       PWDATA,
  output logic                   PREADY,
  output logic [31:0]            PRDATA,
  output logic                   PSLVERR,
  // timekeeping counter side
  input  wire rca_pkg::rca_time_t TIME_NOW,
  input  wire logic              TIME_STEP,
  output rca_pkg::rca_adj_t      CAL_ADJ,
  // alarm outputs
  output logic                   ALARM_IRQ,
  output logic                   ALARM_PULSE
);
  import rca_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // match function

  function automatic logic digits_match(input logic [3:0] mask, input rca_time_t t,
                                        input rca_alval_t a);
    logic s1;
    logic s;
    logic m1;
    logic m;
    logic h;
    s1 = (t.sec[3:0] == a.sec[3:0]);
    s  = (t.sec == a.sec);
    m1 = (t.min[3:0] == a.min[3:0]);
    m  = (t.min == a.min);
    h  = (t.hour == a.hour);
    unique case (mask)
      4'h0:    digits_match = 1'b1;
      4'h1:    digits_match = !t.half;
      4'h2:    digits_match = !t.half && s1;
      4'h3:    digits_match = !t.half && s;
      4'h4:    digits_match = !t.half && s && m1;
      4'h5:    digits_match = !t.half && s && m;
      4'h6:    digits_match = !t.half && s && m && h;
      4'h7:    digits_match = !t.half && s && m && h && (t.wday == a.wday);
      4'h8:    digits_match = !t.half && s && m && h && (t.day == a.day);
      4'h9:    digits_match = !t.half && s && m && h && (t.day == a.day) &&
                              (t.month == a.month);
      default: digits_match = 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [7:0]  clock_config_calibration_reg;
  rca_alcfg_t  alarm_config_repeat_reg;
  rca_alcfg_t  alcfg_next;
  rca_alval_t  alarm_compare_value;
  logic        event_reg;
  logic        event_next;
  logic        cal_busy;
  rca_adj_t    cal_adj;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  wire         setup    = PSEL && !PENABLE;
  wire         access   = PSEL && PENABLE && PREADY;
  wire         wr       = access && PWRITE;
  wire         sel_cal  = (PADDR == `RCA_OFS_CAL);
  wire         sel_cfg  = (PADDR == `RCA_OFS_ALCFG);
  wire         sel_tim  = (PADDR == `RCA_OFS_ALTIME);
  wire         sel_dat  = (PADDR == `RCA_OFS_ALDATE);
  wire         sel_st   = (PADDR == `RCA_OFS_STATUS);
  wire         mapped   = sel_cal || sel_cfg || sel_tim || sel_dat || sel_st;

  wire [31:0]  rd_cal   = {24'h000000, clock_config_calibration_reg};
  wire [31:0]  rd_cfg   = {16'h0000, alarm_config_repeat_reg};
  wire [31:0]  rd_tim   = {10'h000, alarm_compare_value.hour, 1'b0, alarm_compare_value.min,
                           1'b0, alarm_compare_value.sec};
  wire [31:0]  rd_dat   = {11'h000, alarm_compare_value.month, 2'b00, alarm_compare_value.day,
                           5'h00, alarm_compare_value.wday};
  wire [31:0]  rd_st    = {29'h00000000, cal_busy, ALARM_PULSE, event_reg};
  wire [31:0]  rd_mux   = sel_cal ? rd_cal :
                          sel_cfg ? rd_cfg :
                          sel_tim ? rd_tim :
                          sel_dat ? rd_dat :
                          sel_st  ? rd_st  : 32'h00000000;

  // no wait state: ready rises in the first access cycle
  always_ff @(posedge CLK) begin
    if (RST) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h00000000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= setup;
      PSLVERR <= setup && !mapped;
      if (setup) begin
        PRDATA <= PWRITE ? 32'h00000000 : rd_mux;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // calibration

  wire sec_edge  = TIME_STEP && !TIME_NOW.half;
  wire quarter   = (TIME_NOW.sec == `RCA_SEC_00) || (TIME_NOW.sec == `RCA_SEC_15) ||
                   (TIME_NOW.sec == `RCA_SEC_30) || (TIME_NOW.sec == `RCA_SEC_45);
  wire boundary  = sec_edge && quarter;

  rca_cal u_cal (
    .clk      (CLK),
    .rst      (RST),
    .corr     (clock_config_calibration_reg),
    .boundary (boundary),
    .adj      (cal_adj),
    .busy     (cal_busy)
  );

  ////////////////////////////////////////////////////////////////////////////
  // alarm

  wire fire      = alarm_config_repeat_reg.arm && TIME_STEP &&
                   digits_match(alarm_config_repeat_reg.mask, TIME_NOW, alarm_compare_value);
  wire last_one  = (alarm_config_repeat_reg.rpt == 8'h00);

  // hardware update of arm bit and repeat count after an alarm
  always_comb begin
    alcfg_next = alarm_config_repeat_reg;
    if (wr && sel_cfg) begin
      alcfg_next = rca_alcfg_t'(PWDATA[15:0]);
      alcfg_next.unused = 2'b00;
    end else if (fire) begin
      if (!last_one) begin
        alcfg_next.rpt = alarm_config_repeat_reg.rpt - 8'h01;
      end else if (alarm_config_repeat_reg.endless) begin
        alcfg_next.rpt = `RCA_RPT_WRAP;
      end else begin
        alcfg_next.arm = 1'b0;
      end
    end
  end

  // sticky event flag, write one to clear; a new event wins over the clear
  assign event_next = fire || (event_reg && !(wr && sel_st && PWDATA[`RCA_ST_EVENT]));

  always_ff @(posedge CLK) begin
    if (RST) begin
      clock_config_calibration_reg <= `RCA_CAL_RST;
      alarm_config_repeat_reg      <= `RCA_ALCFG_RST;
      alarm_compare_value          <= '0;
      event_reg                    <= 1'b0;
      ALARM_IRQ                    <= 1'b0;
      ALARM_PULSE                  <= 1'b0;
      CAL_ADJ                      <= '0;
    end else begin
      alarm_config_repeat_reg <= alcfg_next;
      event_reg               <= event_next;
      ALARM_IRQ               <= fire;
      ALARM_PULSE             <= ALARM_PULSE ^ fire;
      CAL_ADJ                 <= cal_adj;
      if (wr && sel_cal) begin
        clock_config_calibration_reg <= PWDATA[7:0];
      end
      if (wr && sel_tim) begin
        alarm_compare_value.sec  <= PWDATA[6:0];
        alarm_compare_value.min  <= PWDATA[14:8];
        alarm_compare_value.hour <= PWDATA[21:16];
      end
      if (wr && sel_dat) begin
        alarm_compare_value.wday  <= PWDATA[2:0];
        alarm_compare_value.day   <= PWDATA[13:8];
        alarm_compare_value.month <= PWDATA[20:16];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  irq_follows_a: assert property (@(posedge CLK) disable iff (RST) fire |=> ALARM_IRQ)
    else $error("alarm without interrupt");

  irq_cause_a: assert property (@(posedge CLK) disable iff (RST)
      ALARM_IRQ |-> $past(alarm_config_repeat_reg.arm))
    else $error("interrupt while disarmed");

  pulse_toggle_a: assert property (@(posedge CLK) disable iff (RST)
      ALARM_IRQ |-> ALARM_PULSE != $past(ALARM_PULSE))
    else $error("alarm pulse did not toggle");

  pulse_still_a: assert property (@(posedge CLK) disable iff (RST)
      !ALARM_IRQ |-> $stable(ALARM_PULSE))
    else $error("alarm pulse toggled without alarm");

  final_disarm_a: assert property (@(posedge CLK) disable iff (RST)
      (fire && last_one && !alarm_config_repeat_reg.endless && !(wr && sel_cfg))
      |=> !alarm_config_repeat_reg.arm)
    else $error("arm bit not cleared after final alarm");

  rpt_decr_a: assert property (@(posedge CLK) disable iff (RST)
      (fire && !last_one && !(wr && sel_cfg))
      |=> alarm_config_repeat_reg.rpt == $past(alarm_config_repeat_reg.rpt) - 8'h01
          && alarm_config_repeat_reg.arm)
    else $error("repeat count not decremented");

  endless_wrap_a: assert property (@(posedge CLK) disable iff (RST)
      (fire && last_one && alarm_config_repeat_reg.endless && !(wr && sel_cfg))
      |=> alarm_config_repeat_reg.rpt == 8'hff && alarm_config_repeat_reg.arm)
    else $error("endless repeat did not wrap");

  no_fire_mask_a: assert property (@(posedge CLK) disable iff (RST)
      (alarm_config_repeat_reg.mask > 4'h9) |-> !fire)
    else $error("alarm fired with reserved mask");

  ready_once_a: assert property (@(posedge CLK) disable iff (RST)
      (PSEL && !PENABLE) |=> PREADY ##1 !PREADY)
    else $error("ready not a single cycle");

  cal_quarter_a: assert property (@(posedge CLK) disable iff (RST)
      (cal_busy && !$past(cal_busy)) |-> $past(boundary))
    else $error("calibration burst outside a quarter minute");

  event_set_a: assert property (@(posedge CLK) disable iff (RST)
      fire |=> event_reg)
    else $error("alarm did not set the event flag");

  event_clear_a: assert property (@(posedge CLK) disable iff (RST)
      (wr && sel_st && PWDATA[`RCA_ST_EVENT] && !fire) |=> !event_reg)
    else $error("event flag not cleared by write");

  irq_step_a: assert property (@(posedge CLK) disable iff (RST)
      ALARM_IRQ |-> $past(TIME_STEP))
    else $error("interrupt without a time step");

  arm_hold_a: assert property (@(posedge CLK) disable iff (RST)
      (alarm_config_repeat_reg.arm && !fire && !(wr && sel_cfg)) |=> alarm_config_repeat_reg.arm)
    else $error("arm bit dropped without alarm");

  rpt_hold_a: assert property (@(posedge CLK) disable iff (RST)
      (!fire && !(wr && sel_cfg)) |=> $stable(alarm_config_repeat_reg.rpt))
    else $error("repeat count moved without alarm");

  cfg_write_a: assert property (@(posedge CLK) disable iff (RST)
      (wr && sel_cfg) |=> alarm_config_repeat_reg == {$past(PWDATA[15:10]), 2'b00, $past(PWDATA[7:0])})
    else $error("alarm config write lost");

  cal_write_a: assert property (@(posedge CLK) disable iff (RST)
      (wr && sel_cal) |=> clock_config_calibration_reg == $past(PWDATA[7:0]))
    else $error("correction write lost");

  cal_hold_a: assert property (@(posedge CLK) disable iff (RST)
      !(wr && sel_cal) |=> $stable(clock_config_calibration_reg))
    else $error("correction changed without write");

  compare_hold_a: assert property (@(posedge CLK) disable iff (RST)
      !(wr && (sel_tim || sel_dat)) |=> $stable(alarm_compare_value))
    else $error("alarm compare value changed without write");

  adj_exclusive_a: assert property (@(posedge CLK) disable iff (RST)
      !(CAL_ADJ.add && CAL_ADJ.drop))
    else $error("add and drop requested together");

  adj_burst_a: assert property (@(posedge CLK) disable iff (RST)
      (CAL_ADJ.add || CAL_ADJ.drop) |-> $past(cal_busy, 2))
    else $error("adjust pulse outside a calibration burst");

  fire_half_a: assert property (@(posedge CLK) disable iff (RST)
      (fire && alarm_config_repeat_reg.mask != 4'h0) |-> !TIME_NOW.half)
    else $error("masked alarm fired on a half second");

  slverr_ready_a: assert property (@(posedge CLK) disable iff (RST)
      PSLVERR |-> PREADY)
    else $error("slave error without ready");

  err_rdata_a: assert property (@(posedge CLK) disable iff (RST)
      PSLVERR |-> PRDATA == 32'h00000000)
    else $error("read data not zero on slave error");

  ready_idle_a: assert property (@(posedge CLK) disable iff (RST)
      !PSEL |=> !PREADY)
    else $error("ready without a transfer");

  cfg_read_a: assert property (@(posedge CLK) disable iff (RST)
      (setup && !PWRITE && sel_cfg) |=> PRDATA == {16'h0000, $past(alarm_config_repeat_reg)})
    else $error("alarm config read data wrong");

  status_read_a: assert property (@(posedge CLK) disable iff (RST)
      (setup && !PWRITE && sel_st) |=> PRDATA[`RCA_ST_EVENT] == $past(event_reg))
    else $error("status read data wrong");

endmodule
`default_nettype wire

/* verif/testbench.sv */
// self-checking bench of the calibration and alarm block
`timescale 1ns/1ps
`default_nettype none
`include "rca_consts.svh"

module testbench;
  import rca_pkg::*;
  logic        clk;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  rca_time_t   time_now;
  logic        time_step;
  rca_adj_t    cal_adj;
  logic        alarm_irq;
  logic        alarm_pulse;
  int          errors;
  int          total_checks;
  int          n_add;
  int          n_drop;
  int          n_irq;
  logic [31:0] rd;
  logic        err;
  logic        exp_pulse;

  rca_top dut (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr),
    .TIME_NOW(time_now), .TIME_STEP(time_step), .CAL_ADJ(cal_adj),
    .ALARM_IRQ(alarm_irq), .ALARM_PULSE(alarm_pulse));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // pulse counters sampled before the edge updates land
  always @(posedge clk) begin
    if (cal_adj.add === 1'b1) n_add++;
    if (cal_adj.drop === 1'b1) n_drop++;
    if (alarm_irq === 1'b1) n_irq++;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (n == 16) begin
      errors++;
      $display("[FAIL] %0t apb answer missing", $time);
      final_report();
    end else begin
      rd      = prdata;
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic step(input logic [6:0] s, input logic h);
    @(posedge clk);
    time_now.sec  <= s;
    time_now.half <= h;
    time_step     <= 1'b1;
    @(posedge clk);
    time_step <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic cal_case(input int c, input logic [6:0] s, input logic h, input logic fire);
    int a0;
    int d0;
    logic [7:0] cb;
    cb = 8'(c);
    step(7'h01, 1'b0);
    apb(1'b1, `RCA_OFS_CAL, {24'h0, cb});
    apb(1'b0, `RCA_OFS_CAL, 32'h0);
    chk(rd, {24'h0, cb}, "cal readback");
    a0 = n_add;
    d0 = n_drop;
    step(s, h);
    repeat (140) @(posedge clk);
    chk(32'(n_add - a0), (fire && c > 0) ? 32'(c) : 32'h0, "added pulses");
    chk(32'(n_drop - d0), (fire && c < 0) ? 32'(-c) : 32'h0, "dropped pulses");
    $display("test cal %0d at %h done", c, s);
  endtask

  task automatic alarm_case(input logic endl, input logic [3:0] mask, input logic [7:0] rpt,
                            input int nsteps);
    logic arm;
    logic fire;
    logic any;
    logic [6:0] s;
    int i0;
    arm = 1'b1;
    any = 1'b0;
    apb(1'b1, `RCA_OFS_ALCFG, 32'h0);
    apb(1'b1, `RCA_OFS_STATUS, 32'h1);
    apb(1'b1, `RCA_OFS_ALTIME, 32'h20);
    apb(1'b1, `RCA_OFS_ALCFG, {16'h0, 1'b1, endl, mask, 2'b00, rpt});
    for (int i = 0; i < nsteps; i++) begin
      s = i[0] ? 7'h20 : 7'h21;
      fire = arm && (mask == 4'h0 || (mask == 4'h3 && s == 7'h20));
      i0 = n_irq;
      step(s, 1'b0);
      repeat (3) @(posedge clk);
      if (fire) begin
        any = 1'b1;
        exp_pulse = ~exp_pulse;
        if (rpt != 8'h00) rpt = rpt - 8'h01;
        else if (endl) rpt = `RCA_RPT_WRAP;
        else arm = 1'b0;
      end
      chk(32'(n_irq - i0), {31'h0, fire}, "alarm irq count");
      chk({31'h0, alarm_pulse}, {31'h0, exp_pulse}, "alarm pulse level");
    end
    apb(1'b0, `RCA_OFS_ALCFG, 32'h0);
    chk(rd, {16'h0, arm, endl, mask, 2'b00, rpt}, "alarm config after run");
    apb(1'b0, `RCA_OFS_STATUS, 32'h0);
    chk({29'h0, rd[2:0]}, {30'h0, exp_pulse, any}, "status after run");
    apb(1'b1, `RCA_OFS_STATUS, 32'h1);
    apb(1'b0, `RCA_OFS_STATUS, 32'h0);
    chk({31'h0, rd[0]}, 32'h0, "status event cleared");
    $display("test alarm e%0b m%0h done", endl, mask);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [6:0] secs [4];
    int c;
    secs = '{7'h00, 7'h15, 7'h30, 7'h45};
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    time_now = '0;
    time_step = 1'b0;
    errors = 0;
    total_checks = 0;
    exp_pulse = 1'b0;
    void'($urandom(32'hc1a89fb1));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, `RCA_OFS_CAL, 32'h0);
    chk(rd, {24'h0, `RCA_CAL_RST}, "cal reset value");
    apb(1'b0, `RCA_OFS_ALCFG, 32'h0);
    chk(rd, {16'h0, `RCA_ALCFG_RST}, "alarm config reset value");
    apb(1'b0, 8'h14, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped address error");
    chk(rd, 32'h0, "unmapped read data");
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      c = int'($urandom_range(1, 127));
      if (i[0]) c = -c;
      cal_case(c, secs[i], 1'b0, 1'b1);
    end
    cal_case(-128, 7'h15, 1'b0, 1'b1);
    cal_case(127, 7'h30, 1'b0, 1'b1);
    cal_case(1, 7'h00, 1'b0, 1'b1);
    cal_case((32768 - 32767) * 60 / `RCA_SLICES, 7'h15, 1'b0, 1'b1);
    cal_case(5, 7'h16, 1'b0, 1'b0);
    cal_case(-5, 7'h45, 1'b1, 1'b0);
    alarm_case(1'b0, 4'h0, 8'h00, 3);
    alarm_case(1'b0, 4'h0, 8'h02, 4);
    alarm_case(1'b1, 4'h0, 8'h00, 3);
    alarm_case(1'b0, 4'h0, 8'hff, 3);
    alarm_case(1'b0, 4'h3, 8'h01, 6);
    alarm_case(1'b0, 4'hc, 8'h00, 2);
    final_report();
  end
endmodule

`default_nettype wire
